//--- logic/irq_sel_defines.svh
// Purpose: offsets, field positions and reset values of the interrupt source selector
// Assumes: 32-bit registers, one aligned word each, byte addressed
// Notes:   definitions only, shared by the selector and its helpers
`ifndef IRQ_SEL_DEFINES_SVH
`define IRQ_SEL_DEFINES_SVH

// register byte addresses
`define ADDR_SEL_HIGH    32'h019C0000
`define ADDR_SEL_LOW     32'h019C0004
`define ADDR_EXT_POL     32'h019C0008
`define ADDR_IRQ_STATUS  32'h019C0010
`define ADDR_IRQ_ENABLE  32'h019C0014
`define ADDR_IRQ_CLEAR   32'h019C0018

// selector field layout, same in both select registers
`define SEL_WIDTH        5
`define SEL_FIELD_LSB0   0
`define SEL_FIELD_LSB1   5
`define SEL_FIELD_LSB2   10
`define SEL_FIELD_LSB3   16
`define SEL_FIELD_LSB4   21
`define SEL_FIELD_LSB5   26
`define SEL_USED_MASK    32'h7FFF7FFF
`define POL_USED_MASK    32'h0000000F

// selector defaults for cpu inputs 4 to 15
`define SEL_RST_IN4      5'h04
`define SEL_RST_IN5      5'h05
`define SEL_RST_IN6      5'h06
`define SEL_RST_IN7      5'h07
`define SEL_RST_IN8      5'h08
`define SEL_RST_IN9      5'h09
`define SEL_RST_IN10     5'h03
`define SEL_RST_IN11     5'h0A
`define SEL_RST_IN12     5'h0B
`define SEL_RST_IN13     5'h00
`define SEL_RST_IN14     5'h01
`define SEL_RST_IN15     5'h02

// other reset values
`define RST_CPU_IRQ      16'h0001
`define RST_POLARITY     4'h0
`define RST_IRQ_BITS     12'h000
`define RST_RDATA        32'h00000000

`endif

//--- logic/irq_sel_pkg.sv
// Purpose: types of the interrupt source selector
// Assumes: constants live in irq_sel_defines.svh
// Notes:   no timing constants, the block has no timed behaviour
package irq_sel_pkg;
  // bus handshake states, one bit so the path is trivially gray
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
  typedef logic [4:0]         sel_code_t;  // one selector field
  typedef sel_code_t [11:0]   sel_bank_t;  // lane 0 is cpu input 4
endpackage : irq_sel_pkg

//--- logic/pin_sync.sv
// Purpose: two-flop synchroniser for pins entering the ref_clk domain
// Assumes: synchronous active-low reset
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire  logic         ref_clk,
  input  wire  logic         rst_b,
  // pins in, synchronised levels out
  input  wire  logic [W-1:0] pin_in,
  output logic       [W-1:0] pin_out
);
  logic [W-1:0] meta_q;  // metastable stage
  logic [W-1:0] meta_d;
  logic [W-1:0] out_d;

  // next values
  always_comb begin
    meta_d  = pin_in;
    out_d   = meta_q;
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= meta_d;
      pin_out <= out_d;
    end
  end
endmodule : pin_sync

//--- logic/irq_event_mux.sv
// Purpose: routes one of 32 event sources to each selectable cpu lane
// Assumes: sources are levels on ref_clk; reserved codes carry a zero source
// Notes:   purely combinational, the caller registers the result
`timescale 1ns/10ps
module irq_event_mux
  import irq_sel_pkg::*;
#(
  parameter int LANES = 12
) (
  // source vector indexed by selector code
  input  wire  logic [31:0]      src,
  // selector codes, lane 0 first
  input  wire  sel_code_t [LANES-1:0] sel,
  // selected events
  output logic [LANES-1:0]       lane_out
);
  // pick the source that a code names
  function automatic logic pick(input logic [31:0] s, input sel_code_t c);
    pick = s[c];
  endfunction : pick

  // each lane follows its own code
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_out[i] = pick(src, sel[i]);
    end
  end
endmodule : irq_event_mux

//--- logic/cpu_interrupt_source_selector.sv
// Purpose: selects the event that drives each cpu interrupt input, with an Avalon-MM register port
// Assumes: peripheral events are ref_clk levels; nmi and external pins are asynchronous
// Notes:   inputs 0..3 are fixed, 4..15 follow their selector field
// Contract
// - sixteen prioritized cpu inputs, zero is reset
// - inputs zero to three fixed, unmaskable
// - inputs four to fifteen follow selected source
// - selector codes written into high/low registers
// - low register fields feed inputs four-nine
// - high register fields feed inputs ten-fifteen
// - selector fields reset to default sources
// - lower codes map host, timers, pins, dma
// - upper codes map serial, video, audio, others
// - polarity register inverts external pins four-seven
`timescale 1ns/10ps
`include "irq_sel_defines.svh"
module cpu_interrupt_source_selector
  import irq_sel_pkg::*;
(
  // clock and reset
  input  wire  logic        ref_clk,
  input  wire  logic        rst_b,
  // avalon-mm slave
  input  wire  logic [31:0] address,
  input  wire  logic        read,
  input  wire  logic        write,
  input  wire  logic [31:0] writedata,
  input  wire  logic [3:0]  byteenable,
  output logic       [31:0] readdata,
  output logic              waitrequest,
  // asynchronous pins
  input  wire  logic        nmi_pin,
  input  wire  logic        external_pin_irq_4,
  input  wire  logic        external_pin_irq_5,
  input  wire  logic        external_pin_irq_6,
  input  wire  logic        external_pin_irq_7,
  // peripheral events on ref_clk
  input  wire  logic        host_to_cpu_irq,
  input  wire  logic        timer_zero_irq,
  input  wire  logic        timer_one_irq,
  input  wire  logic        timer_two_irq,
  input  wire  logic        refresh_timer_irq,
  input  wire  logic        gpio_irq_4,
  input  wire  logic        gpio_irq_5,
  input  wire  logic        gpio_irq_6,
  input  wire  logic        gpio_irq_7,
  input  wire  logic        gpio_irq_zero,
  input  wire  logic        dma_completion_irq,
  input  wire  logic        emulation_dma_event,
  input  wire  logic        emulation_exchange_rx,
  input  wire  logic        emulation_exchange_tx,
  input  wire  logic        serial0_transmit_irq,
  input  wire  logic        serial0_receive_irq,
  input  wire  logic        serial1_transmit_irq,
  input  wire  logic        serial1_receive_irq,
  input  wire  logic        twowire_bus_irq,
  input  wire  logic        ethernet_mgmt_irq,
  input  wire  logic        video_port0_irq,
  input  wire  logic        video_port1_irq,
  input  wire  logic        video_port2_irq,
  input  wire  logic        audio_transmit_irq,
  input  wire  logic        audio_receive_irq,
  // towards the cpu and the system
  output logic       [15:0] cpu_irq,
  output logic              irq
);

  // state
  bus_state_t   st_q,     st_d;      // bus handshake
  sel_bank_t    sel_q,    sel_d;     // selector fields, lane 0 is input 4
  logic [3:0]   pol_q,    pol_d;     // external pin polarity
  logic [11:0]  status_q, status_d;  // sticky lane rises
  logic [11:0]  en_q,     en_d;      // interrupt enables
  logic [31:0]  rdata_d;             // next read data
  logic         wait_d;              // next waitrequest
  logic [15:0]  cpu_irq_d;           // next cpu lanes
  logic         irq_d;               // next interrupt level
  logic [11:0]  clr_mask;            // write-one-to-clear bits this cycle
  logic [11:0]  rise;                // lane rising edges
  logic [31:0]  be_m;                // byte enables as a bit mask
  logic [31:0]  wr_img;              // select register image after a write
  logic [31:0]  wr_msk;              // writable bits of this write
  int           wr_base;             // first lane of the addressed register

  // sources
  logic [4:0]   pin_s;               // synchronised nmi and external pins
  logic [3:0]   pin_src;             // gpio or corrected external pin
  logic [31:0]  src;                 // source vector by selector code
  logic [11:0]  sel_out;             // selected events

  // field lsb inside a select register
  function automatic int field_lsb(input int j);
    case (j)
      0:       field_lsb = `SEL_FIELD_LSB0;
      1:       field_lsb = `SEL_FIELD_LSB1;
      2:       field_lsb = `SEL_FIELD_LSB2;
      3:       field_lsb = `SEL_FIELD_LSB3;
      4:       field_lsb = `SEL_FIELD_LSB4;
      default: field_lsb = `SEL_FIELD_LSB5;
    endcase
  endfunction : field_lsb

  // pack six lanes from base into a register image, gaps read zero
  function automatic logic [31:0] pack6(input sel_bank_t b, input int base);
    logic [31:0] r;
    r = '0;
    for (int j = 0; j < 6; j++) begin
      r[field_lsb(j) +: `SEL_WIDTH] = b[base + j];
    end
    pack6 = r;
  endfunction : pack6

  // byte enables as a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // default bank after reset
  function automatic sel_bank_t default_bank();
    default_bank = {`SEL_RST_IN15, `SEL_RST_IN14, `SEL_RST_IN13, `SEL_RST_IN12,
                    `SEL_RST_IN11, `SEL_RST_IN10, `SEL_RST_IN9,  `SEL_RST_IN8,
                    `SEL_RST_IN7,  `SEL_RST_IN6,  `SEL_RST_IN5,  `SEL_RST_IN4};
  endfunction : default_bank

  // pins cross into ref_clk before anything looks at them
  pin_sync #(
    .W (5)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin_in  ({external_pin_irq_7, external_pin_irq_6, external_pin_irq_5, external_pin_irq_4, nmi_pin}),
    .pin_out (pin_s)
  );

  // pin sources: polarity applied before the selector, gpio shares the code
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_src[i] = (pin_s[i+1] ^ pol_q[i]);
    end
    pin_src = pin_src | {gpio_irq_7, gpio_irq_6, gpio_irq_5, gpio_irq_4};
  end

  // source vector by code; reserved codes carry zero
  always_comb begin
    src     = '0;
    src[0]  = host_to_cpu_irq;
    src[1]  = timer_zero_irq;
    src[2]  = timer_one_irq;
    src[3]  = refresh_timer_irq;
    src[7:4] = pin_src;
    src[8]  = dma_completion_irq;
    src[9]  = emulation_dma_event;
    src[10] = emulation_exchange_rx;
    src[11] = emulation_exchange_tx;
    src[12] = serial0_transmit_irq;
    src[13] = serial0_receive_irq;
    src[14] = serial1_transmit_irq;
    src[15] = serial1_receive_irq;
    src[16] = gpio_irq_zero;
    src[19] = timer_two_irq;
    src[22] = twowire_bus_irq;
    src[24] = ethernet_mgmt_irq;
    src[25] = video_port0_irq;
    src[26] = video_port1_irq;
    src[27] = video_port2_irq;
    src[28] = audio_transmit_irq;
    src[29] = audio_receive_irq;
  end

  // selectable lanes follow their field
  irq_event_mux #(
    .LANES (12)
  ) u_mux (
    .src      (src),
    .sel      (sel_q),
    .lane_out (sel_out)
  );

  // bus handshake and register next values
  always_comb begin
    st_d     = st_q;
    wait_d   = 1'b1;
    rdata_d  = readdata;
    sel_d    = sel_q;
    pol_d    = pol_q;
    en_d     = en_q;
    clr_mask = '0;
    be_m     = be_mask(byteenable);
    wr_img   = '0;
    wr_msk   = '0;
    wr_base  = 0;
    case (st_q)
      BUS_IDLE: begin
        // take the request, answer one cycle later
        if (read || write) begin
          st_d   = BUS_ACK;
          wait_d = 1'b0;
          if (read) begin
            if (address == `ADDR_SEL_HIGH) begin
              rdata_d = pack6(sel_q, 6);
            end else if (address == `ADDR_SEL_LOW) begin
              rdata_d = pack6(sel_q, 0);
            end else if (address == `ADDR_EXT_POL) begin
              rdata_d = {28'h0000000, pol_q};
            end else if (address == `ADDR_IRQ_STATUS) begin
              rdata_d = {20'h00000, status_q};
            end else if (address == `ADDR_IRQ_ENABLE) begin
              rdata_d = {20'h00000, en_q};
            end else begin
              rdata_d = `RST_RDATA;   // clear register and unmapped read zero
            end
          end
        end
      end
      BUS_ACK: begin
        // the write lands on the edge where waitrequest is seen low
        st_d = BUS_IDLE;
        if (write) begin
          if (address == `ADDR_SEL_HIGH || address == `ADDR_SEL_LOW) begin
            wr_base = (address == `ADDR_SEL_HIGH) ? 6 : 0;
            wr_msk  = be_m & `SEL_USED_MASK;
            wr_img  = (pack6(sel_q, wr_base) & ~wr_msk) | (writedata & wr_msk);
            for (int j = 0; j < 6; j++) begin
              sel_d[wr_base + j] = wr_img[field_lsb(j) +: `SEL_WIDTH];
            end
          end else if (address == `ADDR_EXT_POL) begin
            if (byteenable[0]) begin
              pol_d = writedata[3:0];
            end
          end else if (address == `ADDR_IRQ_ENABLE) begin
            en_d = (en_q & ~be_m[11:0]) | (writedata[11:0] & be_m[11:0]);
          end else if (address == `ADDR_IRQ_CLEAR) begin
            clr_mask = writedata[11:0] & be_m[11:0];
          end
        end
      end
      default: st_d = BUS_IDLE;
    endcase
  end

  // lanes, sticky status and interrupt level
  always_comb begin
    cpu_irq_d = {sel_out, 2'b00, pin_s[0], 1'b0};
    rise      = sel_out & ~cpu_irq[15:4];
    status_d  = (status_q & ~clr_mask) | rise;  // a rise beats a clear in the same cycle
    irq_d     = |(status_q & en_q);
  end

  // registers only; every output is a flop
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q        <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= `RST_RDATA;
      sel_q       <= default_bank();
      pol_q       <= `RST_POLARITY;
      status_q    <= `RST_IRQ_BITS;
      en_q        <= `RST_IRQ_BITS;
      cpu_irq     <= `RST_CPU_IRQ;
      irq         <= 1'b0;
    end else begin
      st_q        <= st_d;
      waitrequest <= wait_d;
      readdata    <= rdata_d;
      sel_q       <= sel_d;
      pol_q       <= pol_d;
      status_q    <= status_d;
      en_q        <= en_d;
      cpu_irq     <= cpu_irq_d;
      irq         <= irq_d;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_high;
    st_q == BUS_ACK && write && address == `ADDR_SEL_HIGH && byteenable == 4'hF;
  endsequence
  sequence s_wr_low;
    st_q == BUS_ACK && write && address == `ADDR_SEL_LOW && byteenable == 4'hF;
  endsequence
  sequence s_rd_sel;
    st_q == BUS_IDLE && read && (address == `ADDR_SEL_HIGH || address == `ADDR_SEL_LOW);
  endsequence

  reset_lane_a: assert property (cpu_irq[0] == !$past(rst_b))
    else $error("lane zero does not mark reset");
  fixed_lanes_a: assert property (cpu_irq[3:2] == 2'b00 && cpu_irq[1] == $past(pin_s[0]))
    else $error("fixed lanes wrong");
  lane_follow_a: assert property ($past(rst_b) |-> cpu_irq[15:4] == $past(sel_out))
    else $error("selectable lane does not follow its source");
  high_write_a: assert property (s_wr_high |=> pack6(sel_q, 6) == ($past(writedata) & `SEL_USED_MASK))
    else $error("high select write lost");
  low_layout_a: assert property (s_wr_low |=> sel_q[0] == $past(writedata[4:0]) && sel_q[5] == $past(writedata[30:26]))
    else $error("low select layout wrong");
  high_layout_a: assert property (s_wr_high |=> sel_q[6] == $past(writedata[4:0]) && sel_q[9] == $past(writedata[20:16]))
    else $error("high select layout wrong");
  reset_default_a: assert property ($past(!rst_b) |-> sel_q[0] == 5'h04 && sel_q[6] == 5'h03 && sel_q[9] == 5'h00)
    else $error("selector defaults wrong");
  timer_code_a: assert property (sel_q[0] == 5'h01 |-> sel_out[0] == timer_zero_irq)
    else $error("timer code misrouted");
  twowire_code_a: assert property (sel_q[6] == 5'h16 |-> sel_out[6] == twowire_bus_irq)
    else $error("two-wire code misrouted");
  pin_polarity_a: assert property (sel_q[0] == 5'h04 && !gpio_irq_4 |-> sel_out[0] == (pin_s[1] ^ pol_q[0]))
    else $error("pin polarity not applied");
  gap_bits_a: assert property (s_rd_sel |=> !waitrequest && readdata[15] == 1'b0 && readdata[31] == 1'b0)
    else $error("unused selector bits not zero");
  select_effect_a: assert property (s_wr_low ##1 rst_b |=> cpu_irq[4] == $past(src[sel_q[0]]))
    else $error("selector change late");
  sticky_set_a: assert property (rise[3] |=> status_q[3])
    else $error("lane rise not captured");
endmodule : cpu_interrupt_source_selector

//--- bench/tb_top.sv
// Purpose: self-checking bench for the cpu interrupt source selector
// Assumes: one-wait Avalon slave; lanes register their source one edge late
// Notes:   pins pass a two-flop synchroniser, so settle waits five edges
`timescale 1ns/10ps
`include "irq_sel_defines.svh"
module tb_top
  import irq_sel_pkg::*;
;
  // clock, reset and bus
  logic        ref_clk;
  logic        rst_b;
  logic [31:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  // pins and events
  logic        nmi_pin;
  logic [3:0]  ext_pin;      // external pins 4..7
  logic [31:0] srcv;         // peripheral events, indexed by selector code
  logic [15:0] cpu_irq;
  logic        irq;
  // bookkeeping
  int          bad_count;
  int          checks_done;
  logic [31:0] rd;           // word taken by the last read
  // reserved selector codes 17,18,20,21,23,30,31
  localparam logic [31:0] rsvd_mask = 32'hC0B60000;
  localparam sel_code_t dflt_codes [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                            5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
  // distinct non-default sources, one per lane
  localparam sel_code_t prog_codes [12] = '{5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h13,
                                            5'h16, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};

  cpu_interrupt_source_selector cpu_interrupt_source_selector_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .nmi_pin(nmi_pin), .external_pin_irq_4(ext_pin[0]), .external_pin_irq_5(ext_pin[1]),
    .external_pin_irq_6(ext_pin[2]), .external_pin_irq_7(ext_pin[3]),
    .host_to_cpu_irq(srcv[0]), .timer_zero_irq(srcv[1]), .timer_one_irq(srcv[2]),
    .refresh_timer_irq(srcv[3]), .gpio_irq_4(srcv[4]), .gpio_irq_5(srcv[5]), .gpio_irq_6(srcv[6]),
    .gpio_irq_7(srcv[7]), .dma_completion_irq(srcv[8]), .emulation_dma_event(srcv[9]),
    .emulation_exchange_rx(srcv[10]), .emulation_exchange_tx(srcv[11]),
    .serial0_transmit_irq(srcv[12]), .serial0_receive_irq(srcv[13]), .serial1_transmit_irq(srcv[14]),
    .serial1_receive_irq(srcv[15]), .gpio_irq_zero(srcv[16]), .timer_two_irq(srcv[19]),
    .twowire_bus_irq(srcv[22]), .ethernet_mgmt_irq(srcv[24]), .video_port0_irq(srcv[25]),
    .video_port1_irq(srcv[26]), .video_port2_irq(srcv[27]), .audio_transmit_irq(srcv[28]),
    .audio_receive_irq(srcv[29]), .cpu_irq(cpu_irq), .irq(irq)
  );

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // packs six fields, bits 15 and 31 left zero
  function automatic logic [31:0] pack(input sel_code_t c [6]);
    pack = {1'b0, c[5], c[4], c[3], 1'b0, c[2], c[1], c[0]};
  endfunction : pack

  // closing report, the only place the run ends
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one Avalon access; request held until waitrequest is sampled low
  task automatic bus_op(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // a slave that never answers ends the run
    if (n == 20) begin
      bad_count++;
      $display("BAD t=%0t bus timeout", $time);
      tally_and_finish;
    end
  endtask : bus_op

  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    bus_op(1'b1, a, d);
  endtask : bus_write

  task automatic bus_read(input logic [31:0] a);
    bus_op(1'b0, a, 32'h00000000);
  endtask : bus_read

  // five edges covers the synchroniser plus the lane register
  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle

  // raises each lane's source alone and expects that lane alone
  task automatic lane_sweep(input sel_code_t t [12]);
    for (int k = 0; k < 12; k++) begin
      @(posedge ref_clk) srcv <= 32'h1 << t[k];
      settle;
      check(32'(cpu_irq[15:4]), 32'h1 << k);
    end
    @(posedge ref_clk) srcv <= 32'h0;
  endtask : lane_sweep

  // register defaults and default routing
  task automatic defaults_test;
    bus_read(`ADDR_SEL_HIGH);
    check(rd, pack(dflt_codes[6:11]));
    bus_read(`ADDR_SEL_LOW);
    check(rd, pack(dflt_codes[0:5]));
    bus_read(`ADDR_EXT_POL);
    check(rd, 32'h00000000);
    lane_sweep(dflt_codes);
  endtask : defaults_test

  // each polarity bit inverts only its own pin
  task automatic polarity_test;
    for (int i = 0; i < 4; i++) begin
      bus_write(`ADDR_EXT_POL, 32'h1 << i);
      settle;
      check(32'(cpu_irq[7:4]), 32'h1 << i);
    end
    bus_write(`ADDR_EXT_POL, 32'hFFFFFFFF);
    bus_read(`ADDR_EXT_POL);
    check(rd, 32'h0000000F);
    @(posedge ref_clk) ext_pin <= 4'hF;
    settle;
    check(32'(cpu_irq[7:4]), 32'h0);
    bus_write(`ADDR_EXT_POL, 32'h0);
    settle;
    check(32'(cpu_irq[7:4]), 32'hF);
    @(posedge ref_clk) ext_pin <= 4'h0;
  endtask : polarity_test

  // every non-reserved code through lane 4, with the change timed to the edge
  task automatic code_sweep;
    sel_code_t c [6];
    c = dflt_codes[0:5];
    for (int i = 0; i < 32; i++) begin
      // software never programs a reserved code
      if (rsvd_mask[i]) continue;
      c[0] = i[4:0];
      @(posedge ref_clk) srcv <= 32'h1 << i;
      bus_write(`ADDR_SEL_LOW, pack(c));
      #1;
      check(32'(cpu_irq[4]), 32'h0);
      @(posedge ref_clk);
      #1;
      check(32'(cpu_irq[4]), 32'h1);
    end
    @(posedge ref_clk) srcv <= 32'h0;
    bus_write(`ADDR_SEL_LOW, pack(dflt_codes[0:5]));
  endtask : code_sweep

  // sticky status, enable mask and write-one clear
  task automatic irq_flow;
    bus_write(`ADDR_IRQ_CLEAR, 32'h00000FFF);
    bus_write(`ADDR_IRQ_ENABLE, 32'h0);
    settle;
    bus_read(`ADDR_IRQ_STATUS);
    check(rd, 32'h0);
    check(32'(irq), 32'h0);
    @(posedge ref_clk) srcv <= 32'h1;   // host event, lane 13 by default
    settle;
    bus_read(`ADDR_IRQ_STATUS);
    check(rd, 32'h00000200);
    check(32'(irq), 32'h0);             // masked
    bus_write(`ADDR_IRQ_ENABLE, 32'h00000200);
    settle;
    check(32'(irq), 32'h1);
    bus_read(`ADDR_IRQ_ENABLE);
    check(rd, 32'h00000200);
    bus_write(`ADDR_IRQ_CLEAR, 32'h00000200);
    settle;
    check(32'(irq), 32'h0);             // source still high, no new rise
    bus_read(`ADDR_IRQ_CLEAR);
    check(rd, 32'h0);
    @(posedge ref_clk) srcv <= 32'h0;
  endtask : irq_flow

  // unused bits, field positions and an unmapped word
  task automatic field_test;
    // every field gets the legal code 11101, gap bits 15 and 31 set
    bus_write(`ADDR_SEL_LOW, 32'hF7BDF7BD);
    bus_read(`ADDR_SEL_LOW);
    check(rd, 32'h77BD77BD);
    bus_write(`ADDR_SEL_HIGH, 32'hF7BDF7BD);
    bus_read(`ADDR_SEL_HIGH);
    check(rd, 32'h77BD77BD);
    bus_write(`ADDR_SEL_LOW, pack(prog_codes[0:5]));
    bus_write(`ADDR_SEL_HIGH, pack(prog_codes[6:11]));
    lane_sweep(prog_codes);
    bus_write(32'h019C000C, 32'hFFFFFFFF);
    bus_read(32'h019C000C);
    check(rd, 32'h0);
    bus_read(`ADDR_SEL_LOW);
    check(rd, pack(prog_codes[0:5]));
  endtask : field_test

  // nmi reaches input 1, inputs 2 and 3 stay quiet
  task automatic nmi_test;
    @(posedge ref_clk) nmi_pin <= 1'b1;
    settle;
    check(32'(cpu_irq[3:0]), 32'h2);
    @(posedge ref_clk) nmi_pin <= 1'b0;
    settle;
    check(32'(cpu_irq[3:0]), 32'h0);
  endtask : nmi_test

  // main sequence
  initial begin
    bad_count   = 0;
    checks_done = 0;
    rst_b       = 1'b0;
    address     = 32'h0;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = 32'h0;
    byteenable  = 4'hF;
    nmi_pin     = 1'b0;
    ext_pin     = 4'h0;
    srcv        = 32'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    check(32'(cpu_irq), 32'h0001);
    check(32'(waitrequest), 32'h1);
    @(posedge ref_clk) rst_b <= 1'b1;
    settle;
    check(32'(cpu_irq), 32'h0000);
    defaults_test;
    polarity_test;
    code_sweep;
    irq_flow;
    field_test;
    nmi_test;
    tally_and_finish;
  end
endmodule : tb_top
